/* File: design/lio_defs.svh */
`ifndef LIO_DEFS_SVH
`define LIO_DEFS_SVH
`define LIO_ADDR_OD_PORT     3'h0
`define LIO_ADDR_PWM_PORT    3'h1
`define LIO_ADDR_IN_PORT     3'h2
`define LIO_ADDR_SEC_PORT    3'h3
`define LIO_ADDR_SIX_PORT    3'h4
`define LIO_ADDR_PWM_EN      3'h5
`define LIO_ADDR_SYSCTL0     3'h6
`define LIO_ADDR_SYSCTL1     3'h7
`define LIO_LATCH_RST        8'hff
`define LIO_SIX_RST          6'h3f
`define LIO_CTL_RST          8'h00
`define LIO_SC0_ODD_EVEN_BIT 0
`define LIO_SC0_VSYNC_OUTPUT_ENABLE_BIT    1
`define LIO_SC0_P7_ALT_BIT   2
`define LIO_SC1_A17_BIT      0
`define LIO_SC1_A18_BIT      1
`define LIO_SC1_RW_BIT       2
`define LIO_SC1_A19_BIT      3
`define LIO_PULSE_NS         4
`define LIO_CLK_NS           4
`define LIO_PULSE_CYC        ((`LIO_PULSE_NS + `LIO_CLK_NS - 1) / `LIO_CLK_NS)
`endif

/* File: design/lio_pkg.sv */
package lio_pkg;
   typedef logic [7:0] lio_byte_t;
   typedef enum logic [1:0]
   {
      LIO_RD_PIN   = 2'b00,
      LIO_RD_LATCH = 2'b01,
      LIO_RD_CTL   = 2'b10
   } lio_rd_e;
endpackage : lio_pkg

/* File: design/lio_ports.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lio_defs.svh"
// How it works
// RULE_01 - 34 pins: three bytes, six-bit, four-bit input
// RULE_02 - each pin independently input or output anytime; here the four in_pin_i pins of the four-bit port are inputs only
// RULE_03 - plain read returns latch AND pin
// RULE_04 - read-modify-write reads the latch
// RULE_05 - latch one makes pin an input
// RULE_06 - software writes ones to input bits
// RULE_07 - asynchronous pin inputs accepted
// RULE_08 - reset loads all latches with ones
// RULE_09 - listed instructions read the latch
// RULE_10 - bit update rewrites whole latch byte
// RULE_11 - open-drain port floats on latch one
// RULE_12 - one-clock strong pull on zero-to-one
// RULE_13 - port one bits selectable as PWM outputs
// RULE_14 - secondary inputs delivered only when latch one
// RULE_15 - secondary controls follow input-programmed pins
// RULE_16 - secondary functions selected per pin
// RULE_17 - keep secondary bit six high at reset release
// RULE_18 - two-stage synchroniser on every pin input
// RULE_19 - six-bit port address and strobe mapping
module lio_ports
(
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   input  wire logic       ce_i,
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic       rmw_i,
   input  wire logic       bit_wr_i,
   input  wire logic [2:0] bit_sel_i,
   input  wire logic       bit_val_i,
   output logic      [7:0] rdata_o,
   input  wire logic [7:0] od_pin_i,
   output logic      [7:0] od_pin_o,
   output logic      [7:0] od_pin_oe_o,
   input  wire logic [7:0] pwm_pin_i,
   output logic      [7:0] pwm_pin_o,
   output logic      [7:0] pwm_pin_oe_o,
   input  wire logic [7:0] pwm_val_i,
   input  wire logic [3:0] in_pin_i,
   input  wire logic [7:0] sec_pin_i,
   output logic      [7:0] sec_pin_o,
   output logic      [7:0] sec_pin_oe_o,
   input  wire logic       txd_i,
   input  wire logic       odd_even_i,
   output logic      [7:0] sec_func_o,
   input  wire logic [5:0] six_pin_i,
   output logic      [5:0] six_pin_o,
   output logic      [5:0] six_pin_oe_o,
   input  wire logic [2:0] hi_addr_i,
   input  wire logic       rd_strobe_i,
   input  wire logic       wr_strobe_i,
   input  wire logic       vsync_i,
   output logic            vsync_in_o
);
   // Six-bit port: bits 0..4 are pins 0..4, bit 5 is pin 7.
   lio_pkg::lio_byte_t open_drain_port;
   lio_pkg::lio_byte_t pwm_capable_port;
   lio_pkg::lio_byte_t secondary_function_port;
   logic [5:0]         six_bit_port;
   lio_pkg::lio_byte_t pwm_output_enable;
   lio_pkg::lio_byte_t system_control_0;
   lio_pkg::lio_byte_t system_control_1;
   logic [34:0]        sync1; // RULE_01
   logic [34:0]        sync2;
   logic [7:0]         pulse_pwm;
   logic [7:0]         pulse_sec;
   logic [5:0]         pulse_six;
   lio_pkg::lio_byte_t next_latch;
   lio_pkg::lio_byte_t cur_latch;
   lio_pkg::lio_byte_t pin_val;
   logic               wr_any;

   // Pin byte for an address, synchronised view.
   function automatic lio_pkg::lio_byte_t pin_byte(input logic [2:0] a,
                                                    input logic [33:0] s);
      case (a)
         `LIO_ADDR_OD_PORT:  pin_byte = s[7:0];
         `LIO_ADDR_PWM_PORT: pin_byte = s[15:8];
         `LIO_ADDR_IN_PORT:  pin_byte = {4'h0, s[19:16]};
         `LIO_ADDR_SEC_PORT: pin_byte = s[27:20];
         `LIO_ADDR_SIX_PORT: pin_byte = {s[33], 2'h0, s[32:28]};
         default:            pin_byte = 8'h00;
      endcase
   endfunction : pin_byte

   // All pins pass two flops before use. RULE_07
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1 <= '1;
         sync2 <= '1;
      end
      else if (ce_i)
      begin
         sync1 <= {vsync_i, six_pin_i, sec_pin_i, in_pin_i, pwm_pin_i, od_pin_i}; // RULE_18
         sync2 <= sync1; // RULE_07 RULE_18
      end
   end

   always_comb
   begin
      case (addr_i)
         `LIO_ADDR_OD_PORT:  cur_latch = open_drain_port;
         `LIO_ADDR_PWM_PORT: cur_latch = pwm_capable_port;
         `LIO_ADDR_SEC_PORT: cur_latch = secondary_function_port;
         `LIO_ADDR_SIX_PORT: cur_latch = {six_bit_port[5], 2'h3, six_bit_port[4:0]};
         default:            cur_latch = 8'hff;
      endcase
      pin_val = pin_byte(addr_i, sync2[33:0]);
      next_latch = bit_wr_i ? cur_latch : wdata_i;
      if (bit_wr_i)
      begin
         next_latch[bit_sel_i] = bit_val_i; // RULE_10
      end
   end

   assign wr_any = ce_i && (wr_i || bit_wr_i);

   // Latches reset to ones, so all pins start as inputs except six-bit pins 0, 1 and 4, which drive hi_addr_i. RULE_08
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         open_drain_port         <= `LIO_LATCH_RST; // RULE_08
         pwm_capable_port        <= `LIO_LATCH_RST;
         secondary_function_port <= `LIO_LATCH_RST;
         six_bit_port            <= `LIO_SIX_RST;
         pwm_output_enable       <= `LIO_CTL_RST;
         system_control_0        <= `LIO_CTL_RST;
         system_control_1        <= `LIO_CTL_RST;
      end
      else if (wr_any)
      begin
         case (addr_i)
            `LIO_ADDR_OD_PORT:  open_drain_port <= next_latch; // RULE_02
            `LIO_ADDR_PWM_PORT: pwm_capable_port <= next_latch;
            `LIO_ADDR_SEC_PORT: secondary_function_port <= next_latch;
            `LIO_ADDR_SIX_PORT: six_bit_port <= {next_latch[7], next_latch[4:0]};
            `LIO_ADDR_PWM_EN:   pwm_output_enable <= next_latch;
            `LIO_ADDR_SYSCTL0:  system_control_0 <= next_latch;
            `LIO_ADDR_SYSCTL1:  system_control_1 <= next_latch;
            default:            ;
         endcase
      end
   end

   // One-cycle strong drive on a written zero-to-one change. RULE_12
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pulse_pwm <= '0;
         pulse_sec <= '0;
         pulse_six <= '0;
      end
      else if (ce_i)
      begin
         pulse_pwm <= (wr_any && addr_i == `LIO_ADDR_PWM_PORT) ? // RULE_12
                      (next_latch & ~pwm_capable_port) : 8'h00;
         pulse_sec <= (wr_any && addr_i == `LIO_ADDR_SEC_PORT) ?
                      (next_latch & ~secondary_function_port) : 8'h00;
         pulse_six <= (wr_any && addr_i == `LIO_ADDR_SIX_PORT) ?
                      ({next_latch[7], next_latch[4:0]} & ~six_bit_port) : 6'h00;
      end
   end

   // Plain reads see latch AND pin; modify reads see the latch.
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (ce_i && rd_i)
      begin
         if (addr_i >= `LIO_ADDR_PWM_EN)
         begin
            rdata_o <= (addr_i == `LIO_ADDR_PWM_EN) ? pwm_output_enable :
                       (addr_i == `LIO_ADDR_SYSCTL0) ? system_control_0 : system_control_1;
         end
         else if (rmw_i)
         begin
            rdata_o <= cur_latch; // RULE_04 RULE_09
         end
         else
         begin
            rdata_o <= cur_latch & pin_val; // RULE_03
         end
      end
   end

   // Pin drivers: low when latch zero, high pulse, else released. RULE_05 RULE_11
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         od_pin_o     <= '0;
         od_pin_oe_o  <= '0;
         pwm_pin_o    <= '0;
         pwm_pin_oe_o <= '0;
         sec_pin_o    <= '0;
         sec_pin_oe_o <= '0;
         six_pin_o    <= '0;
         six_pin_oe_o <= '0;
         sec_func_o   <= '0;
         vsync_in_o   <= 1'b0;
      end
      else if (ce_i)
      begin
         od_pin_o    <= 8'h00;
         od_pin_oe_o <= ~open_drain_port; // RULE_11
         for (int i = 0; i < 8; i++)
         begin
            if (pwm_output_enable[i]) // RULE_13 RULE_16
            begin
               pwm_pin_o[i]    <= pwm_val_i[i];
               pwm_pin_oe_o[i] <= 1'b1;
            end
            else
            begin
               pwm_pin_o[i]    <= pulse_pwm[i];
               pwm_pin_oe_o[i] <= pulse_pwm[i] | ~pwm_capable_port[i]; // RULE_05
            end
            sec_pin_o[i]    <= pulse_sec[i];
            sec_pin_oe_o[i] <= pulse_sec[i] | ~secondary_function_port[i];
            // Alternate inputs reach peripherals only while the latch holds one.
            sec_func_o[i]   <= secondary_function_port[i] & sync2[20 + i]; // RULE_14 RULE_15
         end
         if (system_control_0[`LIO_SC0_ODD_EVEN_BIT])
         begin
            sec_pin_o[0]    <= odd_even_i;
            sec_pin_oe_o[0] <= 1'b1;
         end
         // Transmit uses output mode: pin one follows the serial line while its latch holds zero.
         if (!secondary_function_port[1])
         begin
            sec_pin_o[1]    <= txd_i; // RULE_14
            sec_pin_oe_o[1] <= 1'b1;
         end
         for (int j = 0; j < 6; j++)
         begin
            six_pin_o[j]    <= pulse_six[j];
            six_pin_oe_o[j] <= pulse_six[j] | ~six_bit_port[j];
         end
         if (!system_control_1[`LIO_SC1_A17_BIT]) // RULE_19
         begin
            six_pin_o[0]    <= hi_addr_i[0];
            six_pin_oe_o[0] <= 1'b1;
         end
         if (!system_control_1[`LIO_SC1_A18_BIT])
         begin
            six_pin_o[1]    <= hi_addr_i[1];
            six_pin_oe_o[1] <= 1'b1;
         end
         if (!system_control_1[`LIO_SC1_A19_BIT])
         begin
            six_pin_o[4]    <= hi_addr_i[2];
            six_pin_oe_o[4] <= 1'b1;
         end
         if (system_control_1[`LIO_SC1_RW_BIT]) // RULE_19
         begin
            six_pin_o[2]    <= rd_strobe_i;
            six_pin_oe_o[2] <= 1'b1;
            six_pin_o[3]    <= wr_strobe_i;
            six_pin_oe_o[3] <= 1'b1;
         end
         if (system_control_0[`LIO_SC0_VSYNC_OUTPUT_ENABLE_BIT])
         begin
            six_pin_o[5]    <= system_control_0[`LIO_SC0_P7_ALT_BIT] ? odd_even_i : sync2[34];
            six_pin_oe_o[5] <= 1'b1;
         end
         vsync_in_o <= sync2[33] & six_bit_port[5];
      end
   end

   property p_od_float; // RULE_11
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i && wr_i && addr_i == `LIO_ADDR_OD_PORT ##1 ce_i |=> od_pin_oe_o == ~$past(open_drain_port);
   endproperty
   a_od_float: assert property (p_od_float) else $error("open drain enable wrong"); // RULE_11

   property p_rmw_latch; // RULE_04
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i && rd_i && rmw_i && addr_i == `LIO_ADDR_PWM_PORT
      |=> rdata_o == $past(pwm_capable_port);
   endproperty
   a_rmw_latch: assert property (p_rmw_latch) else $error("modify read not latch"); // RULE_04

   property p_plain_and; // RULE_03
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i && rd_i && !rmw_i && addr_i == `LIO_ADDR_OD_PORT
      |=> rdata_o == ($past(open_drain_port) & $past(sync2[7:0]));
   endproperty
   a_plain_and: assert property (p_plain_and) else $error("plain read not and"); // RULE_03

   sequence s_rise_sec;
      ce_i && wr_i && !bit_wr_i && addr_i == `LIO_ADDR_SEC_PORT
      && (wdata_i[4] && !secondary_function_port[4]);
   endsequence
   property p_pulse_one; // RULE_12
      @(posedge mclk_i) disable iff (!reset_n_i)
      s_rise_sec ##1 ce_i ##1 ce_i |-> sec_pin_o[4] ##1 (ce_i -> !sec_pin_o[4]);
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("pull pulse wrong"); // RULE_12

   property p_bit_wr; // RULE_10
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i && bit_wr_i && addr_i == `LIO_ADDR_PWM_PORT
      |=> pwm_capable_port == (($past(pwm_capable_port) & ~(8'h01 << $past(bit_sel_i)))
          | ({7'h00, $past(bit_val_i)} << $past(bit_sel_i)));
   endproperty
   a_bit_wr: assert property (p_bit_wr) else $error("bit write wrong"); // RULE_10

   property p_sec_gate; // RULE_14
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i && !secondary_function_port[2] ##1 ce_i |-> !sec_func_o[2];
   endproperty
   a_sec_gate: assert property (p_sec_gate) else $error("alt input leaked"); // RULE_14

   property p_pwm_sel; // RULE_13
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i && pwm_output_enable[6] |=> pwm_pin_oe_o[6] && pwm_pin_o[6] == $past(pwm_val_i[6]);
   endproperty
   a_pwm_sel: assert property (p_pwm_sel) else $error("pwm not routed"); // RULE_13

   property p_input_mode; // RULE_05
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i && pwm_capable_port[3] && !pwm_output_enable[3] && !pulse_pwm[3]
      |=> !pwm_pin_oe_o[3];
   endproperty
   a_input_mode: assert property (p_input_mode) else $error("input pin driven"); // RULE_05

   property p_sync_delay; // RULE_18
      @(posedge mclk_i) disable iff (!reset_n_i)
      ce_i ##1 ce_i |=> sync2[0] == $past(od_pin_i[0], 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong"); // RULE_18
endmodule : lio_ports
`default_nettype wire

/* File: sim/lio_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lio_pin_model
(
   input  wire logic       reset_n_i,
   input  wire logic [7:0] ext_lvl_i,
   input  wire logic [7:0] od_drv_i,
   input  wire logic [7:0] od_en_i,
   input  wire logic [7:0] pw_drv_i,
   input  wire logic [7:0] pw_en_i,
   input  wire logic [7:0] sc_drv_i,
   input  wire logic [7:0] sc_en_i,
   input  wire logic [5:0] sx_drv_i,
   input  wire logic [5:0] sx_en_i,
   output logic      [7:0] od_lvl_o,
   output logic      [7:0] pw_lvl_o,
   output logic      [7:0] sc_lvl_o,
   output logic      [5:0] sx_lvl_o
);
   // A driven pin shows the block's level; a released one shows the external level.
   // The external level may change at any time, with no relation to the clock.
   assign od_lvl_o = (od_en_i & od_drv_i) | (~od_en_i & ext_lvl_i);
   assign pw_lvl_o = (pw_en_i & pw_drv_i) | (~pw_en_i & ext_lvl_i);
   assign sx_lvl_o = (sx_en_i & sx_drv_i) | (~sx_en_i & ext_lvl_i[5:0]);
   // Secondary pin six is kept high while reset is active.
   assign sc_lvl_o = (sc_en_i & sc_drv_i) | (~sc_en_i & ext_lvl_i)
                   | {1'b0, ~reset_n_i, 6'h00};
endmodule : lio_pin_model
`default_nettype wire

/* File: sim/tb_latched_io_ports.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("unexpected %s: expected %h seen %h", nm, exp, got); \
      end \
   end
module tb_latched_io_ports;
   logic       mclk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic       rmw_i = 1'b0, bit_wr_i = 1'b0, bit_val_i = 1'b0, vsync_in_o;
   logic       txd = 1'b0, oddev = 1'b0, rds = 1'b0, wrs = 1'b0, vs = 1'b0;
   logic [2:0] addr_i = 3'h0, bit_sel_i = 3'h0, hi_addr_i = 3'h5;
   logic [3:0] in_pin_i = 4'h9;
   logic [5:0] six_pin_i, six_pin_o, six_pin_oe_o;
   logic [7:0] wdata_i = 8'h00, pwm_val_i = 8'h00, ext = 8'hff, rd_d, rdata_o, sec_func_o;
   logic [7:0] od_pin_i, od_pin_o, od_pin_oe_o, pwm_pin_i, pwm_pin_o, pwm_pin_oe_o;
   logic [7:0] sec_pin_i, sec_pin_o, sec_pin_oe_o;
   int         miscompares = 0, n_tests = 0, n_pu = 0, n_od = 0, pu0 = 0;

   lio_ports DUT
   (
      .mclk_i, .reset_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rmw_i, .bit_wr_i,
      .bit_sel_i, .bit_val_i, .rdata_o, .od_pin_i, .od_pin_o, .od_pin_oe_o, .pwm_pin_i,
      .pwm_pin_o, .pwm_pin_oe_o, .pwm_val_i, .in_pin_i, .sec_pin_i, .sec_pin_o,
      .sec_pin_oe_o, .txd_i(txd), .odd_even_i(oddev), .sec_func_o, .six_pin_i, .six_pin_o,
      .six_pin_oe_o, .hi_addr_i, .rd_strobe_i(rds), .wr_strobe_i(wrs), .vsync_i(vs),
      .vsync_in_o
   );

   lio_pin_model u_pins
   (
      .reset_n_i, .ext_lvl_i(ext), .od_drv_i(od_pin_o), .od_en_i(od_pin_oe_o),
      .pw_drv_i(pwm_pin_o), .pw_en_i(pwm_pin_oe_o), .sc_drv_i(sec_pin_o),
      .sc_en_i(sec_pin_oe_o), .sx_drv_i(six_pin_o), .sx_en_i(six_pin_oe_o),
      .od_lvl_o(od_pin_i), .pw_lvl_o(pwm_pin_i), .sc_lvl_o(sec_pin_i), .sx_lvl_o(six_pin_i)
   );

   always #2 mclk_i = ~mclk_i;

   // Counts clocks of strong high drive: pin zero of the PWM port, any open-drain pin.
   always @(posedge mclk_i)
   begin
      if ((pwm_pin_oe_o[0] & pwm_pin_o[0]) === 1'b1) n_pu++;
      if ((od_pin_oe_o & od_pin_o) !== 8'h00) n_od++;
   end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : idle

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic bw(input logic [2:0] a, input logic [2:0] s, input logic v);
      @(posedge mclk_i);
      addr_i    <= a;
      bit_sel_i <= s;
      bit_val_i <= v;
      bit_wr_i  <= 1'b1;
      @(posedge mclk_i);
      bit_wr_i <= 1'b0;
   endtask : bw

   task automatic rd(input logic [2:0] a, input logic m);
      @(posedge mclk_i);
      addr_i <= a;
      rmw_i  <= m;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      rd_d = rdata_o;
   endtask : rd

   initial
   begin
      #100000;
      miscompares++;
      end_of_test();
   end

   initial
   begin
      repeat (10) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      idle(2);
      `CHK("six oe", 8'h13, {2'h0, six_pin_oe_o})
      `CHK("six addr", 8'h11, {2'h0, six_pin_o & 6'h13})
      `CHK("od oe", 8'h00, od_pin_oe_o)
      `CHK("pwm oe", 8'h00, pwm_pin_oe_o)
      for (int a = 0; a < 5; a++)
      begin
         if (a != 2)
         begin
            rd(3'(a), 1'b1);
            `CHK("reset latch", 8'hff, rd_d)
         end
      end
      rd(3'h5, 1'b1);
      `CHK("reset ctl", 8'h00, rd_d)
      // A write while the block is not enabled must leave the latch alone.
      @(posedge mclk_i);
      ce_i <= 1'b0;
      wr(3'h1, 8'h00);
      ce_i <= 1'b1;
      rd(3'h1, 1'b1);
      `CHK("ce low", 8'hff, rd_d)
      #0.3 ext = 8'h5a;
      wr(3'h1, 8'hf0);
      idle(4);
      rd(3'h1, 1'b0);
      `CHK("pin read", 8'h50, rd_d)
      rd(3'h1, 1'b1);
      `CHK("latch read", 8'hf0, rd_d)
      pu0 = n_pu;
      wr(3'h1, 8'h00);
      wr(3'h1, 8'h01);
      wr(3'h1, 8'h01);
      idle(4);
      `CHK("pull pulses", 8'h01, 8'(n_pu - pu0))
      `CHK("pwm oe", 8'hfe, pwm_pin_oe_o)
      wr(3'h0, 8'h00);
      wr(3'h0, 8'hff);
      idle(4);
      `CHK("od oe", 8'h00, od_pin_oe_o)
      `CHK("od high drive", 8'h00, 8'(n_od))
      rd(3'h0, 1'b0);
      `CHK("od pin read", 8'h5a, rd_d)
      bw(3'h1, 3'h7, 1'b1);
      bw(3'h1, 3'h0, 1'b0);
      rd(3'h1, 1'b1);
      `CHK("bit rewrite", 8'h80, rd_d)
      #0.3 ext = 8'h3c;
      wr(3'h3, 8'he1);
      wr(3'h3, 8'hf1);
      idle(4);
      `CHK("sec func", 8'h30, sec_func_o)
      @(posedge mclk_i);
      txd <= 1'b1;
      idle(2);
      `CHK("sec oe", 8'h0e, sec_pin_oe_o)
      `CHK("txd out", 8'h02, sec_pin_o)
      wr(3'h2, 8'h00);
      rd(3'h2, 1'b0);
      `CHK("input port", 8'h09, {4'h0, rd_d[3:0]})
      @(posedge mclk_i);
      pwm_val_i <= 8'he5;
      wr(3'h5, 8'hc1);
      idle(3);
      `CHK("pwm out", 8'hc1, pwm_pin_o)
      `CHK("pwm oe", 8'hff, pwm_pin_oe_o)
      @(posedge mclk_i);
      pwm_val_i <= 8'h24;
      idle(3);
      `CHK("pwm out", 8'h00, pwm_pin_o)
      wr(3'h7, 8'h0b);
      idle(3);
      `CHK("six oe", 8'h00, {2'h0, six_pin_oe_o})
      `CHK("vs in", 8'h01, {7'h00, vsync_in_o})
      @(posedge mclk_i);
      rds   <= 1'b1;
      oddev <= 1'b1;
      vs    <= 1'b1;
      wr(3'h7, 8'h0f);
      wr(3'h6, 8'h03);
      idle(4);
      `CHK("strobe oe", 8'h2c, {2'h0, six_pin_oe_o})
      `CHK("strobe out", 8'h24, {2'h0, six_pin_o})
      `CHK("odd even oe", 8'h0f, sec_pin_oe_o)
      `CHK("odd even out", 8'h03, sec_pin_o)
      end_of_test();
   end
endmodule : tb_latched_io_ports
`default_nettype wire
